// *** ctrl_input_pkg.sv ***
// Purpose: Shared constants for the discrete control input interpreter
// Assumes: 200 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   Pin indices refer to the debounced control input vector
package ctrl_input_pkg;
	// ==========================================================
	// Control input pin indices
	localparam int PIN_COUNT      = 13;
	localparam int PIN_BACKLIGHT  = 0;  // Force backlight lighting
	localparam int PIN_TOUCH_LOCK = 1;  // Prevent touchscreen use
	localparam int PIN_RESTART    = 2;  // Forced restart
	localparam int PIN_WORK_LSB   = 3;  // Work select weights 1,2,4,8 at 3..6
	localparam int WORK_BITS      = 4;
	localparam int PIN_ZONE       = 7;  // Zone switch
	localparam int PIN_CLEAR      = 8;  // Clear judgment results
	localparam int PIN_INHIBIT    = 9;  // Judgment output disable
	localparam int PIN_START_STOP = 10; // Measurement start/stop
	localparam int PIN_ZERO_BAL   = 11; // Displacement zero balance
	localparam int PIN_DIG_ZERO   = 12; // Digital zero
	localparam int ZONE_COUNT     = 5;

	// ==========================================================
	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CONFIG  = 8'h00;
	localparam logic [7:0] OFS_ZONE_EN = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;
	localparam logic [7:0] OFS_EVENTS  = 8'h0C;
	localparam logic [7:0] OFS_WORK_SW = 8'h10;
	localparam logic [7:0] OFS_ZERO_BAL = 8'h14;
	localparam logic [7:0] OFS_DZ_OFS  = 8'h18;

	// ==========================================================
	// Configuration register fields
	localparam int CFG_WIDTH      = 6;
	localparam int CFG_WORK_EXT   = 0; // Work source is external_input_source
	localparam int CFG_ZONE_EXT   = 1; // Zone source is external_input_source
	localparam int CFG_START_EXT  = 2; // measure_start_condition is external
	localparam int CFG_STOP_EXT   = 3; // measure_stop_condition is external
	localparam int CFG_STYLE      = 4; // external_trigger_style, 1 = level
	localparam int CFG_SERIAL_USB = 5; // Serial goes to front USB port
	localparam logic [CFG_WIDTH-1:0]  CFG_RESET     = 6'h00;
	localparam logic [ZONE_COUNT-1:0] ZONE_EN_RESET = 5'h1F;
	localparam logic [WORK_BITS-1:0]  WORK_SW_RESET = 4'h0;

	// ==========================================================
	// Status register fields
	localparam int ST_WORK_LSB  = 13; // Active work number, 5 bits
	localparam int ST_ZONE_LSB  = 18; // Active zone index, 3 bits
	localparam int ST_MEASURE   = 21;
	localparam int ST_RESTART_P = 22; // Restart waiting for storage idle

	// ==========================================================
	// Sticky event bits, write one to clear
	localparam int EV_WIDTH    = 5;
	localparam int EV_CLEAR    = 0;
	localparam int EV_ZERO_BAL = 1;
	localparam int EV_DIG_ZERO = 2;
	localparam int EV_RESTART  = 3;
	localparam int EV_ZONE     = 4;

	// ==========================================================
	// Timing
	localparam int CLK_FREQ_MHZ        = 200;
	localparam int DEBOUNCE_TIME_US    = 1000;
	localparam int DEBOUNCE_CYCLES     = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;
	localparam int WORK_STABLE_TIME_US = 500;
	localparam int WORK_STABLE_CYCLES  = WORK_STABLE_TIME_US * CLK_FREQ_MHZ;

	// ==========================================================
	// Bus responses and trigger styles
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic {
		STYLE_EDGE  = 1'b0,
		STYLE_LEVEL = 1'b1
	} trigStyle_t;
endpackage : ctrl_input_pkg

// *** ctrl_input_debounce.sv ***
// Purpose: Synchronise and debounce active-low control contacts
// Assumes: Pins are asynchronous to clk; low means shorted to common_return
// Notes:   A level is accepted only after it held for STABLE_CYCLES
`timescale 1ns/100ps
module ctrl_input_debounce #(
	parameter int WIDTH         = 13,
	parameter int STABLE_CYCLES = 200000
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pinN,
	output logic      [WIDTH-1:0] level
);
	localparam int CW = $clog2(STABLE_CYCLES + 1);

	// Refuse settings the counter cannot serve
	initial begin
		if (STABLE_CYCLES < 1 || WIDTH < 1) begin
			$error("ctrl_input_debounce: bad parameters");
		end
	end

	logic [WIDTH-1:0] syncA_reg; // First stage, read only by syncB_reg
	logic [WIDTH-1:0] syncB_reg; // Second stage, safe to use

	// ==========================================================
	// Two-flop synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncA_reg <= '1;
			syncB_reg <= '1;
		end else begin
			syncA_reg <= pinN;
			syncB_reg <= syncA_reg;
		end
	end

	// ==========================================================
	// Per-input stability counter
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic [CW-1:0] cnt_reg;  // Cycles the raw level has differed
			logic [CW-1:0] cnt_next;
			logic          lvl_reg;  // Accepted level, 1 = ON
			logic          lvl_next;
			// Count while the shorted state differs from accepted one
			always_comb begin
				cnt_next = '0;
				lvl_next = lvl_reg;
				if ((~syncB_reg[i]) != lvl_reg) begin
					if (cnt_reg == CW'(STABLE_CYCLES - 1)) begin
						lvl_next = ~syncB_reg[i]; // RQ1 RQ16
					end else begin
						cnt_next = cnt_reg + 1'b1;
					end
				end
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cnt_reg <= '0;
					lvl_reg <= 1'b0;
				end else begin
					cnt_reg <= cnt_next;
					lvl_reg <= lvl_next;
				end
			end
			assign level[i] = lvl_reg;
		end
	endgenerate
endmodule : ctrl_input_debounce

// *** control_input_interpreter.sv ***
// Purpose: Turn isolated discrete control inputs into internal actions
// Assumes: Single 200 MHz clock; storageBusy and sensor values on clk
// Notes:   Registers reached over AXI4-Lite; all outputs are flip-flops
//
// Summary of operation
// [RQ1] Input ON when shorted to common return
// [RQ2] Backlight forced on while input ON
// [RQ3] Touch operations ignored while lockout ON
// [RQ4] Restart on ON, deferred during storage write
// [RQ5] Work number equals binary code plus one
// [RQ6] Work inputs used only with external source
// [RQ7] Zone switch external only, enabled zones only
// [RQ8] Clear results: outputs off, continuous judgment
// [RQ9] Judgment outputs disabled while inhibit ON
// [RQ10] Start/stop used only when condition external
// [RQ11] Edge style toggles on OFF-to-ON only
// [RQ12] Level style: ON starts, OFF stops
// [RQ13] Zero-balance captures present displacement reading
// [RQ14] Digital zero captures present load indication
// [RQ15] Serial uses rear or USB, never both
// [RQ16] Inputs synchronised and debounced before edges
// [RQ17] Work code applied only after stable
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module control_input_interpreter
#(
	parameter int DEBOUNCE     = ctrl_input_pkg::DEBOUNCE_CYCLES,
	parameter int WORK_SETTLE  = ctrl_input_pkg::WORK_STABLE_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [ctrl_input_pkg::PIN_COUNT-1:0] ctrlPinN,
	input  wire logic        storageBusy,
	input  wire logic [31:0] displacementValue,
	input  wire logic [31:0] loadValue,
	input  wire logic [ctrl_input_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [ctrl_input_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             backlightOn,
	output logic             touchEnable,
	output logic             restartReq,
	output logic      [4:0]  workNumber,
	output logic      [2:0]  zoneIndex,
	output logic             judgeClear,
	output logic             judgeDisable,
	output logic             measureRun,
	output logic      [31:0] zeroBalanceRef,
	output logic      [31:0] digitalZeroOffset,
	output logic             serialUsbSel,
	output logic             serialRearSel
);
	import ctrl_input_pkg::*;

	localparam int WSW = $clog2(WORK_SETTLE + 1);

	// Refuse counts the logic cannot serve
	initial begin
		if (DEBOUNCE < 1 || WORK_SETTLE < 1) begin
			$error("control_input_interpreter: bad counts");
		end
	end

	// ==========================================================
	// Debounced input levels
	logic [PIN_COUNT-1:0] level;     // 1 = contact shorted (ON)
	logic [PIN_COUNT-1:0] prev_reg;  // Level one cycle ago
	logic [PIN_COUNT-1:0] rise;      // OFF-to-ON events
	logic [PIN_COUNT-1:0] fall;      // ON-to-OFF events

	ctrl_input_debounce #(
		.WIDTH         (PIN_COUNT),
		.STABLE_CYCLES (DEBOUNCE)
	) u_debounce (
		.clk   (clk),
		.rst   (rst),
		.pinN  (ctrlPinN),
		.level (level)
	);

	assign rise = level & ~prev_reg; // RQ16
	assign fall = ~level & prev_reg;

	// ==========================================================
	// Software-visible state
	logic [CFG_WIDTH-1:0]  cfg_reg, cfg_next;       // Source and style settings
	logic [ZONE_COUNT-1:0] zoneEn_reg, zoneEn_next; // Zones with judgment on
	logic [WORK_BITS-1:0]  workSw_reg, workSw_next; // Work code when internal
	logic [EV_WIDTH-1:0]   events_reg, events_next; // Sticky events
	logic [EV_WIDTH-1:0]   evClear;                 // W1C mask from bus
	logic [EV_WIDTH-1:0]   evSet;                   // Events this cycle

	// ==========================================================
	// Bus state
	logic                awHeld_reg, awHeld_next;
	logic [ADDR_W-1:0]   awAddr_reg, awAddr_next;
	logic                wHeld_reg, wHeld_next;
	logic [31:0]         wData_reg, wData_next;
	logic                wLane0_reg, wLane0_next; // Fields all sit in byte 0
	logic                awready_reg, awready_next;
	logic                wready_reg, wready_next;
	logic                bvalid_reg, bvalid_next;
	logic [1:0]          bresp_reg, bresp_next;
	logic                arready_reg, arready_next;
	logic                rvalid_reg, rvalid_next;
	logic [31:0]         rdata_reg, rdata_next;
	logic [1:0]          rresp_reg, rresp_next;

	// ==========================================================
	// Control state
	logic                 backlight_reg, backlight_next;
	logic                 touchEn_reg, touchEn_next;
	logic                 restartPend_reg, restartPend_next;
	logic                 restartReq_reg, restartReq_next;
	logic [WORK_BITS-1:0] workCand_reg, workCand_next; // Code being watched
	logic [WSW-1:0]       workCnt_reg, workCnt_next;   // Cycles it has held
	logic [WORK_BITS-1:0] workCode_reg, workCode_next; // Accepted code
	logic [4:0]           workNum_reg, workNum_next;
	logic [2:0]           zone_reg, zone_next;
	logic                 judgeClr_reg, judgeClr_next;
	logic                 judgeDis_reg, judgeDis_next;
	logic                 measure_reg, measure_next;
	logic [31:0]          zeroBal_reg, zeroBal_next;
	logic [31:0]          dzOfs_reg, dzOfs_next;
	logic                 serUsb_reg, serUsb_next;
	logic                 serRear_reg, serRear_next;

	// Next enabled zone after the current one, wrapping round
	function automatic logic [2:0] nextZone(input logic [2:0] cur,
		input logic [ZONE_COUNT-1:0] en);
		logic [2:0] res;
		logic [2:0] cand;
		logic       found;
		res   = cur;
		found = 1'b0;
		for (int k = 1; k <= ZONE_COUNT; k++) begin
			cand = 3'((int'(cur) + k) % ZONE_COUNT);
			if (!found && en[cand]) begin
				res   = cand;
				found = 1'b1;
			end
		end
		return res;
	endfunction : nextZone

	// ==========================================================
	// Register bus: write and read channels
	always_comb begin
		awHeld_next = awHeld_reg;
		awAddr_next = awAddr_reg;
		wHeld_next  = wHeld_reg;
		wData_next  = wData_reg;
		wLane0_next = wLane0_reg;
		bvalid_next = bvalid_reg;
		bresp_next  = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		cfg_next    = cfg_reg;
		zoneEn_next = zoneEn_reg;
		workSw_next = workSw_reg;
		evClear     = '0;
		// Address and data are taken independently, in either order
		if (s_axi_awvalid && awready_reg) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			wHeld_next  = 1'b1;
			wData_next  = s_axi_wdata;
			wLane0_next = s_axi_wstrb[0];
		end
		// Response released when the master takes it
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// Perform the write once both halves are held
		if (awHeld_reg && wHeld_reg && !bvalid_reg) begin
			awHeld_next = 1'b0;
			wHeld_next  = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = RESP_OKAY;
			case (awAddr_reg)
				OFS_CONFIG: begin
					if (wLane0_reg) cfg_next = wData_reg[CFG_WIDTH-1:0];
				end
				OFS_ZONE_EN: begin
					if (wLane0_reg) zoneEn_next = wData_reg[ZONE_COUNT-1:0];
				end
				OFS_WORK_SW: begin
					if (wLane0_reg) workSw_next = wData_reg[WORK_BITS-1:0];
				end
				OFS_EVENTS: begin
					if (wLane0_reg) evClear = wData_reg[EV_WIDTH-1:0];
				end
				// Read-only registers accept and discard writes
				OFS_STATUS, OFS_ZERO_BAL, OFS_DZ_OFS: bresp_next = RESP_OKAY;
				default: begin
					bresp_next = RESP_SLVERR;
				end
			endcase
		end
		// Read data released when the master takes it
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			rdata_next  = '0;
			case (s_axi_araddr)
				OFS_CONFIG:   rdata_next[CFG_WIDTH-1:0]  = cfg_reg;
				OFS_ZONE_EN:  rdata_next[ZONE_COUNT-1:0] = zoneEn_reg;
				OFS_WORK_SW:  rdata_next[WORK_BITS-1:0]  = workSw_reg;
				OFS_EVENTS:   rdata_next[EV_WIDTH-1:0]   = events_reg;
				OFS_ZERO_BAL: rdata_next = zeroBal_reg;
				OFS_DZ_OFS:   rdata_next = dzOfs_reg;
				OFS_STATUS: begin
					rdata_next[PIN_COUNT-1:0]          = level;
					rdata_next[ST_WORK_LSB +: 5]       = workNum_reg;
					rdata_next[ST_ZONE_LSB +: 3]       = zone_reg;
					rdata_next[ST_MEASURE]             = measure_reg;
					rdata_next[ST_RESTART_P]           = restartPend_reg;
				end
				default: rresp_next = RESP_SLVERR;
			endcase
		end
		// One outstanding item per channel
		awready_next = !awHeld_next && !bvalid_next;
		wready_next  = !wHeld_next && !bvalid_next;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_reg  <= 1'b0;
			awAddr_reg  <= '0;
			wHeld_reg   <= 1'b0;
			wData_reg   <= 32'h0;
			wLane0_reg  <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= RESP_OKAY;
			cfg_reg     <= CFG_RESET;
			zoneEn_reg  <= ZONE_EN_RESET;
			workSw_reg  <= WORK_SW_RESET;
		end else begin
			awHeld_reg  <= awHeld_next;
			awAddr_reg  <= awAddr_next;
			wHeld_reg   <= wHeld_next;
			wData_reg   <= wData_next;
			wLane0_reg  <= wLane0_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
			cfg_reg     <= cfg_next;
			zoneEn_reg  <= zoneEn_next;
			workSw_reg  <= workSw_next;
		end
	end

	// ==========================================================
	// Input interpretation
	always_comb begin
		trigStyle_t style;
		logic       extMeasure;
		style            = trigStyle_t'(cfg_reg[CFG_STYLE]);
		extMeasure       = cfg_reg[CFG_START_EXT] | cfg_reg[CFG_STOP_EXT];
		evSet            = '0;
		backlight_next   = level[PIN_BACKLIGHT];                    // RQ2
		touchEn_next     = ~level[PIN_TOUCH_LOCK];                  // RQ3
		// A restart waits while removable storage is being written
		restartReq_next  = restartPend_reg & ~storageBusy;          // RQ4
		restartPend_next = (restartPend_reg & storageBusy) | rise[PIN_RESTART];
		evSet[EV_RESTART] = rise[PIN_RESTART];
		// Whole work code must hold before it is accepted
		workCand_next = level[PIN_WORK_LSB +: WORK_BITS];
		workCnt_next  = '0;
		workCode_next = workCode_reg;
		if (workCand_next == workCand_reg) begin
			if (workCnt_reg == WSW'(WORK_SETTLE - 1)) begin
				workCode_next = workCand_reg;                       // RQ17
				workCnt_next  = workCnt_reg;
			end else begin
				workCnt_next = workCnt_reg + 1'b1;
			end
		end
		if (cfg_reg[CFG_WORK_EXT]) begin
			workNum_next = {1'b0, workCode_reg} + 5'h01;            // RQ5 RQ6
		end else begin
			workNum_next = {1'b0, workSw_reg} + 5'h01;
		end
		// Zone stepping skips zones whose judgment is off
		zone_next = zone_reg;
		if (cfg_reg[CFG_ZONE_EXT] && rise[PIN_ZONE]) begin
			zone_next       = nextZone(zone_reg, zoneEn_reg);       // RQ7
			evSet[EV_ZONE]  = 1'b1;
		end
		judgeClr_next   = rise[PIN_CLEAR];                          // RQ8
		evSet[EV_CLEAR] = rise[PIN_CLEAR];
		judgeDis_next   = level[PIN_INHIBIT];                       // RQ9
		// Measurement follows the input only under external conditions
		measure_next = measure_reg;
		if (extMeasure) begin                                       // RQ10
			case (style)
				STYLE_EDGE: begin
					if (rise[PIN_START_STOP]) begin                 // RQ11
						if (!measure_reg && cfg_reg[CFG_START_EXT]) measure_next = 1'b1;
						if (measure_reg && cfg_reg[CFG_STOP_EXT]) measure_next = 1'b0;
					end
				end
				STYLE_LEVEL: begin
					if (rise[PIN_START_STOP] && cfg_reg[CFG_START_EXT]) begin
						measure_next = 1'b1;                        // RQ12
					end
					if (fall[PIN_START_STOP] && cfg_reg[CFG_STOP_EXT]) begin
						measure_next = 1'b0;                        // RQ12
					end
				end
				default: measure_next = measure_reg;
			endcase
		end
		zeroBal_next = rise[PIN_ZERO_BAL] ? displacementValue : zeroBal_reg; // RQ13
		evSet[EV_ZERO_BAL] = rise[PIN_ZERO_BAL];
		dzOfs_next = rise[PIN_DIG_ZERO] ? loadValue : dzOfs_reg;    // RQ14
		evSet[EV_DIG_ZERO] = rise[PIN_DIG_ZERO];
		serUsb_next  = cfg_reg[CFG_SERIAL_USB];                     // RQ15
		serRear_next = ~cfg_reg[CFG_SERIAL_USB];                    // RQ15
		// A new event wins over a clear in the same cycle
		events_next  = (events_reg & ~evClear) | evSet;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_reg        <= '0;
			events_reg      <= '0;
			backlight_reg   <= 1'b0;
			touchEn_reg     <= 1'b1;
			restartPend_reg <= 1'b0;
			restartReq_reg  <= 1'b0;
			workCand_reg    <= '0;
			workCnt_reg     <= '0;
			workCode_reg    <= '0;
			workNum_reg     <= 5'h01;
			zone_reg        <= 3'h0;
			judgeClr_reg    <= 1'b0;
			judgeDis_reg    <= 1'b0;
			measure_reg     <= 1'b0;
			zeroBal_reg     <= 32'h0;
			dzOfs_reg       <= 32'h0;
			serUsb_reg      <= 1'b0;
			serRear_reg     <= 1'b1;
		end else begin
			prev_reg        <= level;
			events_reg      <= events_next;
			backlight_reg   <= backlight_next;
			touchEn_reg     <= touchEn_next;
			restartPend_reg <= restartPend_next;
			restartReq_reg  <= restartReq_next;
			workCand_reg    <= workCand_next;
			workCnt_reg     <= workCnt_next;
			workCode_reg    <= workCode_next;
			workNum_reg     <= workNum_next;
			zone_reg        <= zone_next;
			judgeClr_reg    <= judgeClr_next;
			judgeDis_reg    <= judgeDis_next;
			measure_reg     <= measure_next;
			zeroBal_reg     <= zeroBal_next;
			dzOfs_reg       <= dzOfs_next;
			serUsb_reg      <= serUsb_next;
			serRear_reg     <= serRear_next;
		end
	end

	// ==========================================================
	// Outputs, each straight from a flip-flop
	assign s_axi_awready     = awready_reg;
	assign s_axi_wready      = wready_reg;
	assign s_axi_bvalid      = bvalid_reg;
	assign s_axi_bresp       = bresp_reg;
	assign s_axi_arready     = arready_reg;
	assign s_axi_rvalid      = rvalid_reg;
	assign s_axi_rdata       = rdata_reg;
	assign s_axi_rresp       = rresp_reg;
	assign backlightOn       = backlight_reg;
	assign touchEnable       = touchEn_reg;
	assign restartReq        = restartReq_reg;
	assign workNumber        = workNum_reg;
	assign zoneIndex         = zone_reg;
	assign judgeClear        = judgeClr_reg;
	assign judgeDisable      = judgeDis_reg;
	assign measureRun        = measure_reg;
	assign zeroBalanceRef    = zeroBal_reg;
	assign digitalZeroOffset = dzOfs_reg;
	assign serialUsbSel      = serUsb_reg;
	assign serialRearSel     = serRear_reg;
endmodule : control_input_interpreter

// *** contact_bank.sv ***
// Purpose: Contacts that short control inputs to common_return
// Assumes: An open input is pulled high inside the device
// Notes:   Never drives a voltage, it only closes or opens
`timescale 1ns/100ps
module contact_bank (
	input  wire logic [12:0] closeMask,
	output logic      [12:0] ctrlPinN
);
	// Closed contact reads low, open contact floats to the pull-up
	assign ctrlPinN = ~closeMask;
endmodule : contact_bank

// *** control_input_interpreter_asserts.sv ***
// Purpose: Port checks of the control input interpreter
// Assumes: Short debounce counts, pins held well past them
// Notes:   Pin history depth covers the two sync flops
`timescale 1ns/100ps
module control_input_interpreter_asserts (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [12:0] ctrlPinN,
	input wire logic        storageBusy,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        backlightOn,
	input wire logic        touchEnable,
	input wire logic        restartReq,
	input wire logic [4:0]  workNumber,
	input wire logic [2:0]  zoneIndex,
	input wire logic        judgeClear,
	input wire logic        serialUsbSel,
	input wire logic        serialRearSel
);
	// ====
	// Checks, all on the one clock
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_bwait; s_axi_bvalid && !s_axi_bready; endsequence
	sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
	property p_bhold; s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("bresp lost");
	property p_rhold; s_rwait |=> s_axi_rvalid && $stable(s_axi_rresp); endproperty
	a_rhold: assert property (p_rhold) else $error("rresp lost");
	property p_light; $rose(backlightOn) |-> !$past(ctrlPinN[0], 4); endproperty
	a_light: assert property (p_light) else $error("backlight");
	property p_touch; $fell(touchEnable) |-> !$past(ctrlPinN[1], 4); endproperty
	a_touch: assert property (p_touch) else $error("touch lock");
	property p_busy; storageBusy |=> !restartReq; endproperty
	a_busy: assert property (p_busy) else $error("restart busy");
	property p_work; workNumber inside {[1:16]}; endproperty
	a_work: assert property (p_work) else $error("work range");
	property p_zone; zoneIndex < 3'h5; endproperty
	a_zone: assert property (p_zone) else $error("zone range");
	property p_clr; judgeClear |=> !judgeClear; endproperty
	a_clr: assert property (p_clr) else $error("clear pulse");
	property p_ser; serialUsbSel != serialRearSel; endproperty
	a_ser: assert property (p_ser) else $error("serial port");
endmodule : control_input_interpreter_asserts
bind control_input_interpreter control_input_interpreter_asserts chk (.*);

// *** tb_control_input_interpreter.sv ***
// Purpose: Self-checking bench for the control input interpreter
// Assumes: Debounce and settle counts shortened to 4
// Notes:   Contacts are worked through the contact bank
`timescale 1ns/100ps
module tb_control_input_interpreter;
	import ctrl_input_pkg::*;
	logic        clk, rst, storageBusy, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, backlightOn, touchEnable, restartReq;
	logic        judgeClear, judgeDisable, measureRun, serialUsbSel, serialRearSel;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  zoneIndex;
	logic [3:0]  s_axi_wstrb;
	logic [4:0]  workNumber;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [12:0] ctrlPinN, closeMask;
	logic [31:0] s_axi_wdata, s_axi_rdata, displacementValue, loadValue, zeroBalanceRef;
	logic [31:0] digitalZeroOffset, rdv;
	int          n_errors, checked, pulses;
	// ====
	// Far side, design and clock
	contact_bank far (.closeMask(closeMask), .ctrlPinN(ctrlPinN));
	control_input_interpreter #(.DEBOUNCE(4), .WORK_SETTLE(4)) dut (.*);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Restart and clear pulses counted as they come
	always @(posedge clk) pulses += (restartReq === 1'b1) + (judgeClear === 1'b1);
	// ====
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		if (n_errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	// Idle edge first, so no strobe is set twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, RESP_OKAY);
		if (n == 40) begin
			n_errors++;
			summarize();
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		int n;
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		rdv = s_axi_rdata;
		check(s_axi_rresp, er);
		if (n == 40) begin
			n_errors++;
			summarize();
		end
	endtask : rd
	// Set one contact, then wait out debounce
	task automatic pin(input int i, input logic v);
		closeMask[i] <= v;
		repeat (20) @(posedge clk);
	endtask : pin
	// ====
	// Main sequence
	initial begin
		{rst, s_axi_wstrb} = 5'h1F;
		{storageBusy, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
		{s_axi_wdata, displacementValue, loadValue, closeMask} = 109'h0;
		{n_errors, checked, pulses} = 96'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(workNumber, 32'h1);
		rd(OFS_ZONE_EN, RESP_OKAY);
		check(rdv, 32'h1F);
		rd(8'h20, RESP_SLVERR);
		closeMask[6:3] <= 4'h5;
		wr(OFS_WORK_SW, 32'h3);
		repeat (20) @(posedge clk);
		check(workNumber, 32'h4);
		wr(OFS_CONFIG, 32'h21);
		@(posedge clk);
		check(serialUsbSel, 1'b1);
		for (int c = 0; c < 16; c++) begin
			closeMask[6:3] <= c[3:0];
			repeat (20) @(posedge clk);
			check(workNumber, c + 1);
		end
		pin(0, 1'b1);
		pin(1, 1'b1);
		pin(9, 1'b1);
		check({backlightOn, touchEnable, judgeDisable}, 3'h5);
		closeMask[1:0] <= 2'h0;
		pin(9, 1'b0);
		check({backlightOn, touchEnable, judgeDisable}, 3'h2);
		displacementValue <= 32'h1234ABCD;
		loadValue <= 32'h00C0FFEE;
		pin(11, 1'b1);
		pin(12, 1'b1);
		pin(8, 1'b1);
		check(pulses, 1);
		check(zeroBalanceRef, 32'h1234ABCD);
		check(digitalZeroOffset, 32'h00C0FFEE);
		rd(OFS_EVENTS, RESP_OKAY);
		check(rdv, 32'h7);
		wr(OFS_CONFIG, 32'h0C);
		for (int k = 0; k < 4; k++) begin
			pin(10, ~k[0]);
			check(measureRun, (k + 2) / 2 % 2);
		end
		wr(OFS_CONFIG, 32'h1C);
		pin(10, 1'b1);
		check(measureRun, 1'b1);
		pin(10, 1'b0);
		check(measureRun, 1'b0);
		wr(OFS_CONFIG, 32'h02);
		wr(OFS_ZONE_EN, 32'h05);
		pin(7, 1'b1);
		check(zoneIndex, 3'h2);
		pin(7, 1'b0);
		pin(7, 1'b1);
		check(zoneIndex, 3'h0);
		storageBusy <= 1'b1;
		pin(2, 1'b1);
		check(pulses, 1);
		storageBusy <= 1'b0;
		repeat (5) @(posedge clk);
		check(pulses, 2);
		wr(OFS_EVENTS, 32'h1F);
		rd(OFS_EVENTS, RESP_OKAY);
		check(rdv, 32'h0);
		summarize();
	end
endmodule : tb_control_input_interpreter
